// ---- rlfe_defs.vh ----
// constants for the receive line input front end
`ifndef RLFE_DEFS_VH
`define RLFE_DEFS_VH
`define RLFE_CLK_HZ         100000000
`define RLFE_LOSS_TIME_US   250
`define RLFE_LOSS_CYCLES    ((`RLFE_CLK_HZ / 1000000) * `RLFE_LOSS_TIME_US)
`define RLFE_CNT_W          16
`define RLFE_BPV_W          16
`define RLFE_FIFO_W         2
`define RLFE_FIFO_DEPTH     32
`define RLFE_FIFO_AW        5
`define RLFE_MODE_DS1       1'b1
`define RLFE_MODE_E1        1'b0
`define RLFE_BIT_POS        0
`define RLFE_BIT_NEG        1
`endif

// ---- rlfe_fifo.v ----
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rlfe_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clock_i,
  input  wire             reset_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output reg  [WIDTH-1:0] out_data_o,
  output reg              out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW:0]      wr_ptr_ff;
  reg [AW:0]      rd_ptr_ff;
  wire            full;
  wire            empty;
  wire            do_wr;
  wire            do_rd;
  assign full       = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                      (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty      = (wr_ptr_ff == rd_ptr_ff);
  assign in_ready_o = ~full;
  assign do_wr      = in_valid_i & ~full;
  // output register refills when empty or being taken
  assign do_rd      = ~empty & (~out_valid_o | out_ready_i);
  always @(posedge clock_i) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
    end
  end
  always @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr_ff   <= {(AW+1){1'b0}};
      rd_ptr_ff   <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o  <= {WIDTH{1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff   <= rd_ptr_ff + 1'b1;
        out_data_o  <= mem_ff[rd_ptr_ff[AW-1:0]];
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rlfe_front_end.v ----
// receive line input front end: rail sampling, violation count, clock loss
// How it works
// RQ1 - the clock loss flag rises after 250 us with no edge on the line clock.
// RQ2 - a set clock loss flag clears on the next line clock edge.
// RQ3 - the line partner supplies the clock at 1.544 MHz or 2.048 MHz.
// RQ4 - positive rail data is captured on every line clock rising edge; while the fifo is full the rise is dropped and overflow_o set.
// RQ5 - in single rail the positive rail carries all data, sampled on rising edges.
// RQ6 - in dual rail the negative rail is captured on every rising edge too; it is dropped with the positive rail while the fifo is full.
// RQ7 - in single rail each rising edge with negative rail high adds one to the counter; it holds at all ones and bpv_clear_i in the same cycle wins.
// RQ8 - the framing mode takes the standard select pin level latched at reset release.
// RQ9 - loss timing runs on the system clock and line signals are synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "rlfe_defs.vh"
module rlfe_front_end (
  input  wire                   clock_i,
  input  wire                   reset_i,
  input  wire                   rx_line_clock_i,
  input  wire                   rx_positive_rail_data_i,
  input  wire                   rx_negative_rail_data_i,
  input  wire                   framing_standard_select_i,
  input  wire                   single_rail_i,
  input  wire                   bpv_clear_i,
  input  wire                   out_ready_i,
  output wire [`RLFE_FIFO_W-1:0] out_data_o,
  output wire                   out_valid_o,
  output reg                    ds1_mode_o,
  output reg                    line_clock_loss_flag_o,
  output reg  [`RLFE_BPV_W-1:0] bpv_count_o,
  output reg                    overflow_o
);
  localparam integer           LOSS_INT    = `RLFE_LOSS_CYCLES;
  localparam [`RLFE_CNT_W-1:0] LOSS_CYCLES = LOSS_INT[`RLFE_CNT_W-1:0];
  // two flip-flop synchronisers for clock and rails
  reg [1:0]             clk_sync_ff;
  reg [1:0]             pos_sync_ff;
  reg [1:0]             neg_sync_ff;
  reg [1:0]             sel_sync_ff;
  reg                   clk_last_ff;
  reg                   rst_last_ff;
  reg [`RLFE_CNT_W-1:0] idle_cnt_ff;
  wire                  rise;
  wire                  edge_seen;
  wire [`RLFE_FIFO_W-1:0] sample;
  wire                  fifo_ready;
  always @(posedge clock_i) begin
    if (reset_i) begin
      clk_sync_ff <= 2'h0;
      pos_sync_ff <= 2'h0;
      neg_sync_ff <= 2'h0;
      clk_last_ff <= 1'b0;
    end else begin
      clk_sync_ff <= {clk_sync_ff[0], rx_line_clock_i};           // [RQ9]
      pos_sync_ff <= {pos_sync_ff[0], rx_positive_rail_data_i};
      neg_sync_ff <= {neg_sync_ff[0], rx_negative_rail_data_i};
      clk_last_ff <= clk_sync_ff[1];
    end
  end
  assign rise      = clk_sync_ff[1] & ~clk_last_ff;
  assign edge_seen = clk_sync_ff[1] ^ clk_last_ff;
  // data lags the clock by the same sync depth, so it is taken at the edge
  assign sample[`RLFE_BIT_POS] = pos_sync_ff[1];                     // [RQ4] [RQ5]
  assign sample[`RLFE_BIT_NEG] = single_rail_i ? 1'b0 : neg_sync_ff[1]; // [RQ6]
  // mode latched on the first cycle after reset release; the select pin is a
  // strap, so its synchroniser runs through reset and has settled by release
  always @(posedge clock_i) begin
    rst_last_ff <= reset_i;
    sel_sync_ff <= {sel_sync_ff[0], framing_standard_select_i};
    if (rst_last_ff & ~reset_i) begin
      ds1_mode_o <= sel_sync_ff[1];                                  // [RQ8]
    end else if (reset_i) begin
      ds1_mode_o <= `RLFE_MODE_DS1;
    end
  end
  always @(posedge clock_i) begin
    if (reset_i) begin
      idle_cnt_ff            <= {`RLFE_CNT_W{1'b0}};
      line_clock_loss_flag_o <= 1'b0;
    end else if (edge_seen) begin
      idle_cnt_ff            <= {`RLFE_CNT_W{1'b0}};
      line_clock_loss_flag_o <= 1'b0;                                 // [RQ2]
    end else if (idle_cnt_ff == LOSS_CYCLES - 1'b1) begin
      line_clock_loss_flag_o <= 1'b1;                                 // [RQ1]
    end else begin
      idle_cnt_ff <= idle_cnt_ff + 1'b1;
    end
  end
  always @(posedge clock_i) begin
    if (reset_i) begin
      bpv_count_o <= {`RLFE_BPV_W{1'b0}};
      overflow_o  <= 1'b0;
    end else begin
      if (bpv_clear_i) begin
        bpv_count_o <= {`RLFE_BPV_W{1'b0}};
      end else if (rise & single_rail_i & neg_sync_ff[1] &
                   (bpv_count_o != {`RLFE_BPV_W{1'b1}})) begin
        bpv_count_o <= bpv_count_o + 1'b1;                            // [RQ7]
      end
      if (rise & ~fifo_ready) begin
        overflow_o <= 1'b1;
      end else if (bpv_clear_i) begin
        overflow_o <= 1'b0;
      end
    end
  end
  rlfe_fifo #(
    .WIDTH (`RLFE_FIFO_W),
    .DEPTH (`RLFE_FIFO_DEPTH),
    .AW    (`RLFE_FIFO_AW)
  ) u_fifo (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .in_data_i   (sample),
    .in_valid_i  (rise),
    .in_ready_o  (fifo_ready),
    .out_data_o  (out_data_o),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i)
  );
endmodule
`default_nettype wire

// ---- rlfe_monitor.sv ----
// port assertions for the receive front end
`timescale 1ns/1ps
`default_nettype none
module rlfe_monitor (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        rx_line_clock_i,
  input wire logic        framing_standard_select_i,
  input wire logic        single_rail_i,
  input wire logic        bpv_clear_i,
  input wire logic        out_ready_i,
  input wire logic        out_valid_o,
  input wire logic        ds1_mode_o,
  input wire logic        line_clock_loss_flag_o,
  input wire logic [15:0] bpv_count_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence edge_s; $changed(rx_line_clock_i); endsequence
  sequence quiet_s; !line_clock_loss_flag_o [*8]; endsequence
  AST_NO_EARLY: assert property (edge_s |-> ##5 quiet_s)
    else $error("loss flag high after edge");
  AST_CLEAR: assert property (line_clock_loss_flag_o ##0 edge_s
    |-> ##[1:5] !line_clock_loss_flag_o) else $error("loss flag stuck");
  AST_QUIET: assert property ($rose(line_clock_loss_flag_o) |-> $stable(rx_line_clock_i))
    else $error("loss flag while toggling");
  AST_RISE: assert property ($rose(rx_line_clock_i) |-> ##[1:6] out_valid_o)
    else $error("no sample");
  AST_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o)
    else $error("sample dropped");
  AST_DUAL: assert property ((!single_rail_i && !bpv_clear_i) [*6] |-> $stable(bpv_count_o))
    else $error("count moved in dual rail");
  AST_STEP: assert property (!$past(bpv_clear_i) && $changed(bpv_count_o)
    |-> bpv_count_o == $past(bpv_count_o) + 16'h1) else $error("bad count step");
  AST_MODE: assert property ($fell(reset_i) |=> ds1_mode_o == $past(framing_standard_select_i, 3))
    else $error("bad mode");
endmodule
`default_nettype wire

// ---- rlfe_line_model.sv ----
// line interface model: bursts of 8 bits on a 125 ns line clock
`timescale 1ns/1ps
`default_nettype none
module rlfe_line_model (
  input  wire logic       go_i,
  input  wire logic [7:0] pos_i,
  input  wire logic [7:0] neg_i,
  output var  logic       lclk_o,
  output var  logic       pos_o,
  output var  logic       neg_o
);
  initial begin
    {lclk_o, pos_o, neg_o} = 3'h0;
    forever begin
      @(posedge go_i);
      for (int i = 0; i < 8; i++) begin
        {neg_o, pos_o} = {neg_i[i], pos_i[i]};
        #62.5 lclk_o = 1'b1;
        #62.5 lclk_o = 1'b0;
      end
      {neg_o, pos_o} = ~{neg_o, pos_o};
    end
  end
endmodule
`default_nettype wire

// ---- tb_rlfe_front_end.sv ----
// self-checking bench for the receive front end
`timescale 1ns/1ps
`default_nettype none
module tb_rlfe_front_end;
  logic clock_i = 0, reset_i = 1, framing_standard_select_i = 1, single_rail_i = 0;
  logic bpv_clear_i = 0, out_ready_i = 0, go = 0, ds1_mode_o, line_clock_loss_flag_o;
  logic rx_line_clock_i, rx_positive_rail_data_i, rx_negative_rail_data_i, out_valid_o;
  logic overflow_o;
  logic [1:0] out_data_o;
  logic [15:0] bpv_count_o;
  logic [7:0] pp = 0, nn = 0;
  int err_total = 0, checks = 0, cyc = 0, n;
  always #5 clock_i = ~clock_i;
  rlfe_line_model line (.go_i(go), .pos_i(pp), .neg_i(nn), .lclk_o(rx_line_clock_i),
    .pos_o(rx_positive_rail_data_i), .neg_o(rx_negative_rail_data_i));
  rlfe_front_end dut (
    .clock_i                   (clock_i),
    .reset_i                   (reset_i),
    .rx_line_clock_i           (rx_line_clock_i),
    .rx_positive_rail_data_i   (rx_positive_rail_data_i),
    .rx_negative_rail_data_i   (rx_negative_rail_data_i),
    .framing_standard_select_i (framing_standard_select_i),
    .single_rail_i             (single_rail_i),
    .bpv_clear_i               (bpv_clear_i),
    .out_ready_i               (out_ready_i),
    .out_data_o                (out_data_o),
    .out_valid_o               (out_valid_o),
    .ds1_mode_o                (ds1_mode_o),
    .line_clock_loss_flag_o    (line_clock_loss_flag_o),
    .bpv_count_o               (bpv_count_o),
    .overflow_o                (overflow_o)
  );
  task automatic cmp(input logic [15:0] a, input logic [15:0] e);
    checks++;
    if (a !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task automatic burst(input logic [7:0] p, input logic [7:0] q);
    {pp, nn, go} = {p, q, 1'b1};
    tick(1);
    go = 0;
    for (int i = 0; i < 8; i++) begin
      n = 0;
      while (out_valid_o !== 1'b1 && n < 300) begin
        tick(1);
        n++;
      end
      cmp(out_data_o, {q[i] & ~single_rail_i, p[i]});
      out_ready_i = 1;
      tick(1);
      out_ready_i = 0;
    end
    // let the partner finish its last high half before the next frame
    tick(8);
  endtask
  task automatic fill_drain;
    repeat (5) begin
      go = 1;
      tick(1);
      go = 0;
      tick(110);
    end
    cmp(overflow_o, 16'h1);
    out_ready_i = 1;
    n = 0;
    repeat (80) begin
      if (out_valid_o === 1'b1) n++;
      tick(1);
    end
    cmp(n[15:0], 16'h21);
    out_ready_i = 0;
  endtask
  task stop_test;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      stop_test;
    end
  end
  task automatic mode_check;
    tick(10);
    reset_i = 0;
    tick(2);
    cmp(ds1_mode_o, 16'h1);
    {reset_i, framing_standard_select_i} = 2'h2;
    tick(2);
    reset_i = 0;
    tick(2);
    framing_standard_select_i = 1;
    tick(2);
    cmp(ds1_mode_o, 16'h0);
  endtask
  task automatic single_run;
    {single_rail_i, bpv_clear_i} = 2'h3;
    tick(1);
    bpv_clear_i = 0;
    burst(8'h96, 8'h0f);
    cmp(bpv_count_o, 16'h4);
    single_rail_i = 0;
  endtask
  task automatic clock_loss;
    tick(24800);
    cmp(line_clock_loss_flag_o, 16'h0);
    tick(200);
    cmp(line_clock_loss_flag_o, 16'h1);
    burst(8'h5a, 8'hc3);
    cmp(line_clock_loss_flag_o, 16'h0);
  endtask
  initial begin
    mode_check();
    burst(8'ha5, 8'h3c);
    single_run();
    fill_drain();
    clock_loss();
    stop_test();
  end
endmodule
bind rlfe_front_end rlfe_monitor mon (
  .clock_i                   (clock_i),
  .reset_i                   (reset_i),
  .rx_line_clock_i           (rx_line_clock_i),
  .framing_standard_select_i (framing_standard_select_i),
  .single_rail_i             (single_rail_i),
  .bpv_clear_i               (bpv_clear_i),
  .out_ready_i               (out_ready_i),
  .out_valid_o               (out_valid_o),
  .ds1_mode_o                (ds1_mode_o),
  .line_clock_loss_flag_o    (line_clock_loss_flag_o),
  .bpv_count_o               (bpv_count_o)
);
`default_nettype wire
